// ---- shared/afe_input_consts.svh ----
/*
 Constants of the front-end input configuration block: register byte
 addresses, field positions, reset values and sizes.
 Assumes it is included by the package and the design files by bare name.
*/
`ifndef AFE_INPUT_CONSTS_SVH
`define AFE_INPUT_CONSTS_SVH

// Register byte addresses in I/O memory
`define AFE_MUX_FIRST_ADDR 16'h2100
`define AFE_MUX_LAST_ADDR 16'h2105
`define AFE_PAIR_MODE_ADDR 16'h210C
`define AFE_PREAMP_ADDR 16'h2704
`define AFE_REMOTE_ADDR 16'h2709

// Field positions
`define AFE_PAIR0_DIFF_BIT 4
`define AFE_PAIR_DIFF_MSB 7
`define AFE_PAIR_DIFF_LSB 4
`define AFE_PREAMP_BIT 5
`define AFE_REMOTE_MSB 5
`define AFE_REMOTE_LSB 3
`define AFE_SLOT_COUNT_MSB 7
`define AFE_SLOT_COUNT_LSB 4

// Reset values
`define AFE_REG_RESET 8'h00

// Sizes
`define AFE_MUX_BYTES 6
`define AFE_SLOTS 11
`define AFE_CURRENT_PINS 8
`define AFE_INPUT_PINS 11
`define AFE_REMOTE_PAIRS 3
`define AFE_PREAMP_GAIN 8
`define AFE_FIRST_VOLTAGE_CODE 4'h8
`define AFE_SAMPLE_W 32
`define AFE_CE_ADDR_W 10
`define AFE_FIFO_DEPTH 4

// Compute-engine RAM placement of samples
`define AFE_LOCAL_CE_BASE 10'h000
`define AFE_REMOTE_CE_BASE 10'h010

`endif

// ---- shared/afe_input_pkg.sv ----
/*
 Types of the front-end input configuration block: register bus request,
 configuration image and the word written to compute-engine RAM.
 Assumes afe_input_consts.svh is on the include path.
*/
`include "afe_input_consts.svh"

package afe_input_pkg;

	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	typedef struct packed
	{
		logic [`AFE_MUX_BYTES-1:0][7:0] mux;
		logic [7:0] pair_mode;
		logic [7:0] preamp;
		logic [7:0] remote;
	} cfg_t;

	typedef struct packed
	{
		logic [`AFE_CE_ADDR_W-1:0] addr;
		logic [`AFE_SAMPLE_W-1:0] data;
	} ce_word_t;

	typedef enum logic [1:0]
	{
		SEQ_IDLE = 2'b00,
		SEQ_SELECT = 2'b01,
		SEQ_CONVERT = 2'b10,
		SEQ_STORE = 2'b11
	} seq_state_t;

endpackage

// ---- rtl/afe_sample_fifo.sv ----
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock; write and read may happen in the same cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module afe_sample_fifo
#(
	parameter int WIDTH = 42,
	parameter int DEPTH = 4
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != CW'(DEPTH));
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= bump(wr_ptr);
			if (pop)
				rd_ptr <= bump(rd_ptr);
			if (push && !pop)
				count <= count + CW'(1);
			else if (pop && !push)
				count <= count - CW'(1);
		end
	end

endmodule
`default_nettype wire

// ---- rtl/afe_input_configuration.sv ----
/*
 Front-end input configuration: the I/O memory registers that route the
 eleven converter inputs, the slot sequencer that feeds local inputs to the
 one converter, and the path that puts local and remote samples into
 compute-engine RAM through a FIFO.
 Assumes the converter and decimation filter sit outside and answer each
 conv_start with one conv_done; remote sensor links deliver ready samples.
*/
`timescale 1ns/100ps
`default_nettype none
`include "afe_input_consts.svh"

module afe_input_configuration
	import afe_input_pkg::*;
#(
	parameter int FIFO_DEPTH = `AFE_FIFO_DEPTH
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire bus_req_t mpu_req,
	output logic [7:0] mpu_rdata,
	input wire bus_req_t spi_req,
	output logic [7:0] spi_rdata,
	input wire logic frame_start,
	output logic frame_busy,
	output logic [3:0] conv_select,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [`AFE_SAMPLE_W-1:0] conv_data,
	input wire logic [`AFE_REMOTE_PAIRS-1:0] remote_valid,
	output logic [`AFE_REMOTE_PAIRS-1:0] remote_ready,
	input wire logic [`AFE_REMOTE_PAIRS-1:0][`AFE_SAMPLE_W-1:0] remote_data,
	output logic ce_wr_valid,
	input wire logic ce_wr_ready,
	output ce_word_t ce_wr,
	output logic pair0_differential_enable,
	output logic [3:0] pair_differential,
	output logic preamp_gain8,
	output logic [`AFE_REMOTE_PAIRS-1:0] remote_pair_enable,
	output logic [`AFE_INPUT_PINS-1:0] local_pin_enable
);

	cfg_t cfg;
	cfg_t next_cfg;
	seq_state_t state;
	logic [3:0] slot;
	logic [3:0] slot_count;
	logic [3:0] cur_sel;
	logic [`AFE_SAMPLE_W-1:0] sample;
	logic local_valid;
	logic fifo_in_valid;
	logic fifo_in_ready;
	ce_word_t fifo_in;

	////////////////////////////////////////////////////////////////////////
	// Register helpers

	// Applies one byte write to the configuration image
	function automatic cfg_t apply_write(input cfg_t c, input bus_req_t r);
		cfg_t n;
		n = c;
		if (r.wr)
		begin
			if (r.addr >= `AFE_MUX_FIRST_ADDR && r.addr <= `AFE_MUX_LAST_ADDR)
				n.mux[r.addr[2:0]] = r.wdata;
			else if (r.addr == `AFE_PAIR_MODE_ADDR)
				n.pair_mode = r.wdata;
			else if (r.addr == `AFE_PREAMP_ADDR)
				n.preamp = r.wdata;
			else if (r.addr == `AFE_REMOTE_ADDR)
				n.remote = r.wdata;
		end
		return n;
	endfunction

	// Unmapped addresses read as zero
	function automatic logic [7:0] read_byte(input cfg_t c, input logic [15:0] a);
		logic [7:0] d;
		d = 8'h00;
		if (a >= `AFE_MUX_FIRST_ADDR && a <= `AFE_MUX_LAST_ADDR)
			d = c.mux[a[2:0]];
		else if (a == `AFE_PAIR_MODE_ADDR)
			d = c.pair_mode;
		else if (a == `AFE_PREAMP_ADDR)
			d = c.preamp;
		else if (a == `AFE_REMOTE_ADDR)
			d = c.remote;
		return d;
	endfunction

	// Slot n lives in byte 5 - n/2, low nibble for even n
	function automatic logic [3:0] slot_field(input cfg_t c, input logic [3:0] n);
		logic [7:0] b;
		b = c.mux[3'(`AFE_MUX_BYTES - 1) - n[3:1]];
		return n[0] ? b[7:4] : b[3:0];
	endfunction

	// True when an input code belongs to a pair switched to remote
	function automatic logic code_is_remote(input cfg_t c, input logic [3:0] code);
		logic [2:0] rmt;
		rmt = c.remote[`AFE_REMOTE_MSB:`AFE_REMOTE_LSB];
		if (code >= `AFE_FIRST_VOLTAGE_CODE || code[3:1] == 3'd0)
			return 1'b0;
		return rmt[2'(code[3:1]) - 2'd1];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register file

	// Host write applied first, so the processor wins a same-byte clash
	always_comb
		next_cfg = apply_write(apply_write(cfg, spi_req), mpu_req);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cfg <= '{mux: '0, pair_mode: `AFE_REG_RESET, preamp: `AFE_REG_RESET,
				remote: `AFE_REG_RESET};
		else
			cfg <= next_cfg;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mpu_rdata <= 8'h00;
			spi_rdata <= 8'h00;
		end
		else
		begin
			if (mpu_req.rd)
				mpu_rdata <= read_byte(cfg, mpu_req.addr);
			if (spi_req.rd)
				spi_rdata <= read_byte(cfg, spi_req.addr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Analog routing controls

	assign pair0_differential_enable = cfg.pair_mode[`AFE_PAIR0_DIFF_BIT];
	assign pair_differential = cfg.pair_mode[`AFE_PAIR_DIFF_MSB:`AFE_PAIR_DIFF_LSB];
	assign preamp_gain8 = cfg.preamp[`AFE_PREAMP_BIT];
	assign remote_pair_enable = cfg.remote[`AFE_REMOTE_MSB:`AFE_REMOTE_LSB];

	always_comb
	begin
		for (int i = 0; i < `AFE_INPUT_PINS; i++)
		begin
			if (i < `AFE_CURRENT_PINS)
				local_pin_enable[i] = !code_is_remote(cfg, 4'(i));
			else
				local_pin_enable[i] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slot sequencer

	assign slot_count = cfg.mux[0][`AFE_SLOT_COUNT_MSB:`AFE_SLOT_COUNT_LSB];
	assign cur_sel = slot_field(cfg, slot);
	assign frame_busy = (state != SEQ_IDLE);
	assign local_valid = (state == SEQ_STORE);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= SEQ_IDLE;
			slot <= 4'h0;
			conv_start <= 1'b0;
			conv_select <= 4'h0;
			sample <= '0;
		end
		else
		begin
			conv_start <= 1'b0;
			unique case (state)
				SEQ_IDLE:
				begin
					if (frame_start && slot_count != 4'h0)
					begin
						slot <= 4'h0;
						state <= SEQ_SELECT;
					end
				end
				SEQ_SELECT:
				begin
					if (slot >= slot_count || slot == 4'(`AFE_SLOTS))
						state <= SEQ_IDLE;
					else if (code_is_remote(cfg, cur_sel))
						slot <= slot + 4'h1;
					else
					begin
						conv_select <= cur_sel;
						conv_start <= 1'b1;
						state <= SEQ_CONVERT;
					end
				end
				SEQ_CONVERT:
				begin
					if (conv_done)
					begin
						sample <= conv_data;
						state <= SEQ_STORE;
					end
				end
				SEQ_STORE:
				begin
					if (fifo_in_ready)
					begin
						slot <= slot + 4'h1;
						state <= SEQ_SELECT;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sample path to compute-engine RAM

	// Local sample first, then the lowest pending remote pair
	always_comb
	begin
		logic taken;
		taken = local_valid;
		fifo_in_valid = local_valid;
		fifo_in.addr = `AFE_LOCAL_CE_BASE + `AFE_CE_ADDR_W'(slot);
		fifo_in.data = sample;
		remote_ready = '0;
		for (int k = 0; k < `AFE_REMOTE_PAIRS; k++)
		begin
			if (!remote_pair_enable[k])
				remote_ready[k] = 1'b1;
			else if (!taken && remote_valid[k])
			begin
				taken = 1'b1;
				fifo_in_valid = 1'b1;
				remote_ready[k] = fifo_in_ready;
				fifo_in.addr = `AFE_REMOTE_CE_BASE + `AFE_CE_ADDR_W'(k);
				fifo_in.data = remote_data[k];
			end
		end
	end

	afe_sample_fifo
	#(
		.WIDTH($bits(ce_word_t)),
		.DEPTH(FIFO_DEPTH)
	)
	sample_fifo
	(
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(ce_wr_valid),
		.out_ready(ce_wr_ready),
		.out_data(ce_wr)
	);

endmodule
`default_nettype wire

// ---- dv/afe_input_configuration_sva.sv ----
/* Port assertions of the front-end input configuration.
 Assumes the bind at the foot reaches every instance. */
`timescale 1ns/100ps
`default_nettype none
module afe_input_configuration_sva
	import afe_input_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire bus_req_t mpu_req,
	input wire bus_req_t spi_req,
	input wire logic frame_start,
	input wire logic frame_busy,
	input wire logic conv_start,
	input wire logic pair0_differential_enable,
	input wire logic preamp_gain8,
	input wire logic [2:0] remote_pair_enable,
	input wire logic [10:0] local_pin_enable
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_mpu_wr(a);
		mpu_req.wr && mpu_req.addr == a;
	endsequence
	property p_pair0;
		s_mpu_wr(16'h210C) |=> pair0_differential_enable == $past(mpu_req.wdata[4]);
	endproperty
	a_pair0: assert property (p_pair0) else $error("pair zero mode");
	property p_gain;
		s_mpu_wr(16'h2704) |=> preamp_gain8 == $past(mpu_req.wdata[5]);
	endproperty
	a_gain: assert property (p_gain) else $error("gain bit");
	property p_remote;
		spi_req.wr && spi_req.addr == 16'h2709 && !(mpu_req.wr && mpu_req.addr == 16'h2709)
			|=> remote_pair_enable == $past(spi_req.wdata[5:3]);
	endproperty
	a_remote: assert property (p_remote) else $error("remote bits");
	property p_fixed;
		&{local_pin_enable[1:0], local_pin_enable[10:8]};
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed pins");
	property p_pins;
		local_pin_enable[7:2] == ~{{2{remote_pair_enable[2]}}, {2{remote_pair_enable[1]}},
			{2{remote_pair_enable[0]}}};
	endproperty
	a_pins: assert property (p_pins) else $error("remote pins");
	property p_busy;
		$rose(frame_busy) |-> $past(frame_start);
	endproperty
	a_busy: assert property (p_busy) else $error("busy cause");
	property p_in_frame;
		conv_start |-> frame_busy;
	endproperty
	a_in_frame: assert property (p_in_frame) else $error("start idle");
	property p_pulse;
		conv_start |=> !conv_start;
	endproperty
	a_pulse: assert property (p_pulse) else $error("start long");
endmodule
bind afe_input_configuration afe_input_configuration_sva i_afe_input_configuration_sva (.clock,
	.rst_n, .mpu_req, .spi_req, .frame_start, .frame_busy, .conv_start,
	.pair0_differential_enable, .preamp_gain8, .remote_pair_enable, .local_pin_enable);
`default_nettype wire

// ---- dv/afe_sensor_model.sv ----
/* Converter and remote sensor stand-ins.
 Assumes the block's clock. */
`timescale 1ns/100ps
`default_nettype none
module afe_sensor_model
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic conv_start,
	input wire logic [3:0] conv_select,
	output logic conv_done,
	output logic [31:0] conv_data,
	input wire logic [2:0] remote_go,
	input wire logic [2:0] remote_ready,
	output logic [2:0] remote_valid,
	output logic [2:0][31:0] remote_data
);
	int wait_n;
	logic [3:0] code;
	always @(posedge clock or negedge rst_n)
		if (!rst_n)
		begin
			wait_n <= 0;
			conv_done <= 0;
			conv_data <= 0;
		end
		else
		begin
			conv_done <= 0;
			conv_data <= ~conv_data;
			if (conv_start)
			begin
				wait_n <= slow ? 9 : 1;
				code <= conv_select;
			end
			else if (wait_n > 0)
				wait_n <= wait_n - 1;
			if (!conv_start && wait_n == 1)
			begin
				conv_done <= 1;
				conv_data <= {28'hADC0000, code};
			end
		end
	always @(posedge clock or negedge rst_n)
		if (!rst_n)
		begin
			remote_valid <= 0;
			remote_data <= 0;
		end
		else
			for (int k = 0; k < 3; k++)
				if (remote_go[k] && !remote_valid[k])
				begin
					remote_valid[k] <= 1;
					remote_data[k] <= 32'h5E000000 + k;
				end
				else if (!remote_valid[k] || remote_ready[k])
				begin
					remote_valid[k] <= 0;
					remote_data[k] <= ~remote_data[k];
				end
endmodule
`default_nettype wire

// ---- dv/tb_afe_input_configuration.sv ----
/* Self-checking bench of the front-end input configuration.
 Assumes package, header and sensor model compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_afe_input_configuration;
	import afe_input_pkg::*;
	logic clock = 0;
	logic rst_n = 0;
	bus_req_t mpu_req = '0;
	bus_req_t spi_req = '0;
	logic frame_start = 0;
	logic slow = 0;
	logic stall = 0;
	logic ce_wr_ready = 0;
	logic [2:0] remote_go = 0;
	logic frame_busy, conv_start, conv_done, ce_wr_valid, pair0_differential_enable, preamp_gain8;
	logic [7:0] mpu_rdata, spi_rdata;
	logic [3:0] conv_select, pair_differential;
	logic [31:0] conv_data;
	logic [2:0] remote_valid, remote_ready, remote_pair_enable;
	logic [2:0][31:0] remote_data;
	logic [10:0] local_pin_enable;
	ce_word_t ce_wr;
	logic [31:0] seed = 32'h32ED;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [7:0] regs [int];
	ce_word_t exp_local [$];
	ce_word_t exp_remote [$];
	logic [15:0] addrs [9] = '{16'h2100, 16'h2101, 16'h2102, 16'h2103, 16'h2104, 16'h2105,
		16'h210C, 16'h2704, 16'h2709};
	logic [3:0] counts [5] = '{4'h6, 4'hB, 4'h1, 4'h7, 4'hD};
	afe_input_configuration i_afe_input_configuration (.clock, .rst_n, .mpu_req, .mpu_rdata,
		.spi_req, .spi_rdata, .frame_start, .frame_busy, .conv_select, .conv_start, .conv_done,
		.conv_data, .remote_valid, .remote_ready, .remote_data, .ce_wr_valid, .ce_wr_ready, .ce_wr,
		.pair0_differential_enable, .pair_differential, .preamp_gain8, .remote_pair_enable,
		.local_pin_enable);
	afe_sensor_model i_afe_sensor_model (.clock, .rst_n, .slow, .conv_start, .conv_select,
		.conv_done, .conv_data, .remote_go, .remote_ready, .remote_valid, .remote_data);
	////////////////////////////////////////////////////////////////////////
	initial
		forever #50 clock = ~clock;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string what, input logic [41:0] seen, input logic [41:0] want);
		n_checks++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic host);
		if (host)
			spi_req <= {2'b10, a, d};
		else
			mpu_req <= {2'b10, a, d};
		@(posedge clock);
		mpu_req <= '0;
		spi_req <= '0;
		@(posedge clock);
		if (regs.exists(a))
			regs[a] = d;
	endtask
	task automatic rd(input logic [15:0] a);
		mpu_req <= {2'b01, a, 8'h00};
		spi_req <= {2'b01, a, 8'h00};
		@(posedge clock);
		mpu_req <= '0;
		spi_req <= '0;
		@(negedge clock);
		check("mpu read", mpu_rdata, regs.exists(a) ? regs[a] : 8'h00);
		check("spi read", spi_rdata, regs.exists(a) ? regs[a] : 8'h00);
		@(posedge clock);
	endtask
	task automatic check_cfg;
		logic [2:0] r;
		r = regs[16'h2709][5:3];
		@(negedge clock);
		check("diff0", pair0_differential_enable, regs[16'h210C][4]);
		check("diff", pair_differential, regs[16'h210C][7:4]);
		check("gain", preamp_gain8, regs[16'h2704][5]);
		check("remote", remote_pair_enable, r);
		check("pins", local_pin_enable, {3'h7, {2{~r[2]}}, {2{~r[1]}}, {2{~r[0]}}, 2'h3});
		@(posedge clock);
	endtask
	task automatic frame(input logic [3:0] count, input logic hold);
		logic [3:0] c;
		int n;
		for (int s = 0; s < count && s < 11; s++)
		begin
			c = s % 2 ? regs[16'h2105 - s / 2][7:4] : regs[16'h2105 - s / 2][3:0];
			if (!(c inside {[2:7]} && regs[16'h2709][3 + (c - 2) / 2]))
				exp_local.push_back({10'(s), 28'hADC0000, c});
		end
		for (int k = 0; k < 3; k++)
			if (regs[16'h2709][3 + k])
				exp_remote.push_back({10'(16 + k), 32'h5E000000 + k});
		stall <= hold;
		remote_go <= 3'h7;
		frame_start <= 1;
		@(posedge clock);
		remote_go <= 0;
		frame_start <= 0;
		@(negedge clock);
		check("busy", frame_busy, 1'b1);
		n = 0;
		while ((frame_busy !== 0 || exp_local.size() + exp_remote.size() > 0) && n < 3000)
		begin
			@(negedge clock);
			n++;
			if (n == 80)
				stall <= 0;
		end
		check("frame end", n < 3000, 1'b1);
		@(posedge clock);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clock)
	begin
		seed <= lfsr(seed);
		ce_wr_ready <= !stall && (seed[0] || seed[1]);
		if (ce_wr_valid === 1'b1 && ce_wr_ready)
			if (ce_wr.addr >= 10'h010)
				check("remote word", ce_wr, exp_remote.size() ? exp_remote.pop_front() : '1);
			else
				check("local word", ce_wr, exp_local.size() ? exp_local.pop_front() : '1);
	end
	initial
	begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		test_done;
	end
	initial
	begin
		foreach (addrs[i])
			regs[addrs[i]] = 8'h00;
		repeat (12) @(posedge clock);
		check("reset pins", {remote_ready, local_pin_enable}, 14'h3FFF);
		rst_n <= 1;
		@(posedge clock);
		foreach (addrs[i])
			rd(addrs[i]);
		foreach (addrs[i])
			wr(addrs[i], seed[7:0], i[0]);
		wr(16'h2106, 8'h5A, 0);
		foreach (addrs[i])
			rd(addrs[i]);
		rd(16'h2106);
		mpu_req <= {2'b10, 16'h2704, 8'h20};
		spi_req <= {2'b10, 16'h2704, 8'h00};
		@(posedge clock);
		mpu_req <= '0;
		spi_req <= '0;
		@(posedge clock);
		regs[16'h2704] = 8'h20;
		check_cfg;
		foreach (counts[f])
		begin
			wr(16'h2100, 8'h00, 0);
			frame_start <= 1;
			@(posedge clock);
			frame_start <= 0;
			@(negedge clock);
			check("idle", frame_busy, 1'b0);
			@(posedge clock);
			for (int b = 1; b < 6; b++)
				wr(16'(16'h2100 + b), {4'(seed[15:8] % 11), 4'(seed[7:0] % 11)}, b[0]);
			wr(16'h2709, seed[7:0], 1);
			wr(16'h2704, seed[7:0], 0);
			wr(16'h210C, f == 4 ? 8'hF0 : seed[7:0], 0);
			wr(16'h2100, {counts[f], 4'(seed[7:0] % 11)}, 0);
			check_cfg;
			slow <= f[0];
			frame(counts[f], f == 1);
		end
		test_done;
	end
endmodule
`default_nettype wire
